// *** design/can_irq_select.sv ***
`timescale 1ns/10ps
module can_irq_select (
  // pending sources
  input  wire logic [can_tim_pkg::NUM_OBJ-1:0] objPend,
  input  wire logic                            statusPend,
  // selected identifier
  output logic [can_tim_pkg::ID_W-1:0]         sourceCode
);

  // scan from the top so the lowest object number is left standing
  always_comb begin
    sourceCode = can_tim_pkg::INT_NONE;
    for (int i = can_tim_pkg::NUM_OBJ - 1; i >= 0; i--) begin
      if (objPend[i]) begin
        sourceCode = can_tim_pkg::ID_W'(i + 1);
      end
    end
    if (statusPend) begin
      sourceCode = can_tim_pkg::INT_STATUS;
    end
  end

endmodule

// *** design/can_sync2.sv ***
`timescale 1ns/10ps
module can_sync2 (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // level in and out
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1_r;

  // recessive level at reset so no false edge is seen
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_r <= 1'b1;
      syncOut  <= 1'b1;
    end else begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end

endmodule

// *** design/can_tim_pkg.sv ***
package can_tim_pkg;

  // bus geometry
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_OFS  = 32'h4005_0000;
  localparam logic [ADDR_W-1:0] STAT_OFS  = 32'h4005_0004;
  localparam logic [ADDR_W-1:0] BT_OFS    = 32'h4005_000c;
  localparam logic [ADDR_W-1:0] IDENT_OFS = 32'h4005_0010;
  localparam logic [ADDR_W-1:0] TEST_OFS  = 32'h4005_0014;
  localparam logic [ADDR_W-1:0] PEXT_OFS  = 32'h4005_0018;
  localparam logic [ADDR_W-1:0] PEND_OFS  = 32'h4005_0040;

  // controller_control_register layout
  localparam int CTRL_W         = 8;
  localparam int CTRL_INIT_BIT  = 0;
  localparam int CTRL_IRQEN_BIT = 1;
  localparam int CTRL_CFGEN_BIT = 6;
  localparam int CTRL_TEST_BIT  = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h01;

  // bit_timing_config: field order matches bits 14:0
  typedef struct packed {
    logic [2:0] postSeg;
    logic [3:0] preSeg;
    logic [1:0] jumpWidth;
    logic [5:0] prescaler;
  } bt_cfg_s;
  localparam int BT_W = 15;
  localparam logic [BT_W-1:0] BT_RST = 15'h2301;

  // prescaler_extension
  localparam int PEXT_W = 4;
  localparam logic [PEXT_W-1:0] PEXT_RST = 4'h0;
  localparam int DIV_W = PEXT_W + 6;

  // transmit pin override
  typedef enum logic [1:0] {
    TX_CTRL   = 2'b00,
    TX_SAMPLE = 2'b01,
    TX_LOW    = 2'b10,
    TX_HIGH   = 2'b11
  } tx_mode_e;

  // test_mode_control bits 6:2, receive monitor at bit 7
  typedef struct packed {
    tx_mode_e txMode;
    logic     loopback;
    logic     silent;
    logic     basic;
  } test_cfg_s;
  localparam int TEST_W   = 5;
  localparam int TEST_LSB = 2;
  localparam int TEST_RX_BIT = 7;
  localparam logic [TEST_W-1:0] TEST_RST = 5'h00;

  // interrupt identifier
  localparam int NUM_OBJ = 32;
  localparam int ID_W    = 16;
  localparam logic [ID_W-1:0] INT_NONE   = 16'h0000;
  localparam logic [ID_W-1:0] INT_STATUS = 16'h8000;

  // bit time segments
  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_PRE  = 2'b01,
    SEG_POST = 2'b10
  } seg_e;
  localparam int SEG_CNT_W = 5;

endpackage

// *** design/can_timing_irq_test.sv ***
`timescale 1ns/10ps
module can_timing_irq_test (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  // register port
  input  wire logic [can_tim_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic [can_tim_pkg::DATA_W-1:0]    regWdata,
  input  wire logic                              regWrite,
  input  wire logic                              regRead,
  output logic      [can_tim_pkg::DATA_W-1:0]    regRdata,
  // interrupt events and line
  input  wire logic [can_tim_pkg::NUM_OBJ-1:0]   objIrqSet,
  input  wire logic                              statusIrqSet,
  output logic                                   irqOut,
  // protocol engine side
  input  wire logic                              ctrlTxBit,
  output logic                                   rxBit,
  output logic                                   sampledBit,
  output logic                                   samplePulse,
  output logic                                   bitStartPulse,
  output logic                                   quantumTick,
  output logic                                   basicMode,
  output logic                                   silentMode,
  output logic                                   loopbackMode,
  // transceiver pins
  input  wire logic                              canRx,
  output logic                                   canTx
);

  // register state
  logic [can_tim_pkg::CTRL_W-1:0]  ctrl_r;
  can_tim_pkg::bt_cfg_s            bt_r;
  logic [can_tim_pkg::PEXT_W-1:0]  pext_r;
  can_tim_pkg::test_cfg_s          test_r;
  logic [can_tim_pkg::NUM_OBJ-1:0] objPend_r;
  logic                            statusPend_r;
  logic [can_tim_pkg::ID_W-1:0]    sourceCode;

  // bus decode
  logic wrCtrl;
  logic wrBt;
  logic wrPext;
  logic wrTest;
  logic wrPend;
  logic rdStat;
  logic cfgOpen;
  logic testOpen;

  // pin and bit timing
  logic                               rxSync;
  logic                               rxInt;
  logic                               rxPrev_r;
  logic                               logicTx;
  logic [can_tim_pkg::DIV_W-1:0]      divisor;
  logic [can_tim_pkg::DIV_W-1:0]      presc_r;
  can_tim_pkg::seg_e                  seg_r;
  logic [can_tim_pkg::SEG_CNT_W-1:0]  segCnt_r;
  logic [can_tim_pkg::SEG_CNT_W-1:0]  segNext;
  logic [can_tim_pkg::SEG_CNT_W-1:0]  jumpLen;
  logic [can_tim_pkg::SEG_CNT_W-1:0]  preLen;
  logic [can_tim_pkg::SEG_CNT_W-1:0]  postLen;
  logic [can_tim_pkg::SEG_CNT_W-1:0]  postLeft;
  logic [can_tim_pkg::SEG_CNT_W-1:0]  lengthen_r;
  logic [can_tim_pkg::SEG_CNT_W-1:0]  shorten_r;
  logic                               resyncDone_r;
  logic                               syncEdge;
  logic                               preDone;
  logic                               postDone;
  logic                               bitEnd;

  assign wrCtrl   = regWrite && (regAddr == can_tim_pkg::CTRL_OFS);
  assign wrBt     = regWrite && (regAddr == can_tim_pkg::BT_OFS);
  assign wrPext   = regWrite && (regAddr == can_tim_pkg::PEXT_OFS);
  assign wrTest   = regWrite && (regAddr == can_tim_pkg::TEST_OFS);
  assign wrPend   = regWrite && (regAddr == can_tim_pkg::PEND_OFS);
  assign rdStat   = regRead && (regAddr == can_tim_pkg::STAT_OFS);
  assign cfgOpen  = ctrl_r[can_tim_pkg::CTRL_CFGEN_BIT] && ctrl_r[can_tim_pkg::CTRL_INIT_BIT];
  assign testOpen = ctrl_r[can_tim_pkg::CTRL_TEST_BIT];

  // control register, all bits writable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= can_tim_pkg::CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_r <= regWdata[can_tim_pkg::CTRL_W-1:0];
    end
  end

  // timing fields stay frozen while the engine may be running
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bt_r <= can_tim_pkg::BT_RST;
    end else if (wrBt && cfgOpen) begin
      bt_r <= can_tim_pkg::bt_cfg_s'(regWdata[can_tim_pkg::BT_W-1:0]);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pext_r <= can_tim_pkg::PEXT_RST;
    end else if (wrPext && cfgOpen) begin
      pext_r <= regWdata[can_tim_pkg::PEXT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      test_r <= can_tim_pkg::TEST_RST;
    end else if (wrTest && testOpen) begin
      test_r <= can_tim_pkg::test_cfg_s'(regWdata[can_tim_pkg::TEST_LSB +: can_tim_pkg::TEST_W]);
    end
  end

  // pending flags: a set in the clearing cycle wins
  genvar g;
  generate
    for (g = 0; g < can_tim_pkg::NUM_OBJ; g++) begin : gPend
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          objPend_r[g] <= 1'b0;
        end else if (objIrqSet[g]) begin
          objPend_r[g] <= 1'b1;
        end else if (wrPend && regWdata[g]) begin
          objPend_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      statusPend_r <= 1'b0;
    end else if (statusIrqSet) begin
      statusPend_r <= 1'b1;
    end else if (rdStat) begin
      statusPend_r <= 1'b0;
    end
  end

  can_irq_select uSelect (
    .objPend    (objPend_r),
    .statusPend (statusPend_r),
    .sourceCode (sourceCode)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= (sourceCode != can_tim_pkg::INT_NONE) && ctrl_r[can_tim_pkg::CTRL_IRQEN_BIT];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= '0;
    end else begin
      regRdata <= '0;
      if (regRead) begin
        case (regAddr)
          can_tim_pkg::CTRL_OFS:  regRdata[can_tim_pkg::CTRL_W-1:0] <= ctrl_r;
          can_tim_pkg::BT_OFS:    regRdata[can_tim_pkg::BT_W-1:0] <= bt_r;
          can_tim_pkg::PEXT_OFS:  regRdata[can_tim_pkg::PEXT_W-1:0] <= pext_r;
          can_tim_pkg::IDENT_OFS: regRdata[can_tim_pkg::ID_W-1:0] <= sourceCode;
          can_tim_pkg::PEND_OFS:  regRdata <= objPend_r;
          can_tim_pkg::TEST_OFS: begin
            regRdata[can_tim_pkg::TEST_LSB +: can_tim_pkg::TEST_W] <= test_r;
            regRdata[can_tim_pkg::TEST_RX_BIT] <= rxSync;
          end
          default: regRdata <= '0;
        endcase
      end
    end
  end

  // receive pin and mode selection
  can_sync2 uRxSync (
    .clk     (clk),
    .arst_n  (arst_n),
    .asyncIn (canRx),
    .syncOut (rxSync)
  );

  // silent keeps the bus recessive under TX_CTRL; loop-back feeds our own bit back
  assign logicTx = test_r.silent ? 1'b1 : ctrlTxBit;
  assign rxInt   = test_r.loopback ? logicTx : rxSync;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      basicMode    <= 1'b0;
      silentMode   <= 1'b0;
      loopbackMode <= 1'b0;
      rxBit        <= 1'b1;
    end else begin
      basicMode    <= test_r.basic;
      silentMode   <= test_r.silent;
      loopbackMode <= test_r.loopback;
      rxBit        <= rxInt;
    end
  end

  // any override other than controller breaks normal frames by design
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      canTx <= 1'b1;
    end else begin
      case (test_r.txMode)
        can_tim_pkg::TX_CTRL:   canTx <= logicTx;
        can_tim_pkg::TX_SAMPLE: canTx <= samplePulse;
        can_tim_pkg::TX_LOW:    canTx <= 1'b0;
        can_tim_pkg::TX_HIGH:   canTx <= 1'b1;
        default:                canTx <= 1'b1;
      endcase
    end
  end

  // quantum divider: counts 0..divisor, so divisor plus one cycles
  assign divisor = {pext_r, bt_r.prescaler};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_r <= '0;
    end else if (presc_r >= divisor) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + 1'b1;
    end
  end

  assign quantumTick = (presc_r >= divisor);

  // segment lengths in quanta, each field plus one
  assign jumpLen  = can_tim_pkg::SEG_CNT_W'(bt_r.jumpWidth) + 1'b1;
  assign preLen   = can_tim_pkg::SEG_CNT_W'(bt_r.preSeg) + 1'b1 + lengthen_r;
  assign postLen  = can_tim_pkg::SEG_CNT_W'(bt_r.postSeg) + 1'b1;
  assign segNext  = segCnt_r + 1'b1;
  assign postLeft = postLen - segNext;
  assign preDone  = quantumTick && (seg_r == can_tim_pkg::SEG_PRE) && (segNext >= preLen);
  assign postDone = quantumTick && (seg_r == can_tim_pkg::SEG_POST) && (segNext + shorten_r >= postLen);
  assign bitEnd   = postDone;

  // only a recessive to dominant edge after a recessive sample counts
  assign syncEdge = rxPrev_r && !rxInt && sampledBit && !resyncDone_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxPrev_r <= 1'b1;
    end else begin
      rxPrev_r <= rxInt;
    end
  end

  // bit sequencer: sync quantum, pre-sample, post-sample
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seg_r    <= can_tim_pkg::SEG_SYNC;
      segCnt_r <= '0;
    end else if (quantumTick) begin
      case (seg_r)
        can_tim_pkg::SEG_SYNC: begin
          seg_r    <= can_tim_pkg::SEG_PRE;
          segCnt_r <= '0;
        end
        can_tim_pkg::SEG_PRE: begin
          if (preDone) begin
            seg_r    <= can_tim_pkg::SEG_POST;
            segCnt_r <= '0;
          end else begin
            segCnt_r <= segNext;
          end
        end
        can_tim_pkg::SEG_POST: begin
          if (postDone) begin
            seg_r    <= can_tim_pkg::SEG_SYNC;
            segCnt_r <= '0;
          end else begin
            segCnt_r <= segNext;
          end
        end
        default: begin
          seg_r    <= can_tim_pkg::SEG_SYNC;
          segCnt_r <= '0;
        end
      endcase
    end
  end

  // phase correction, one per bit, clipped to the jump width
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lengthen_r   <= '0;
      shorten_r    <= '0;
      resyncDone_r <= 1'b0;
    end else if (bitEnd) begin
      lengthen_r   <= '0;
      shorten_r    <= '0;
      resyncDone_r <= 1'b0;
    end else if (syncEdge && seg_r == can_tim_pkg::SEG_PRE) begin
      lengthen_r   <= (segNext > jumpLen) ? jumpLen : segNext;
      resyncDone_r <= 1'b1;
    end else if (syncEdge && seg_r == can_tim_pkg::SEG_POST) begin
      shorten_r    <= (postLeft > jumpLen) ? jumpLen : postLeft;
      resyncDone_r <= 1'b1;
    end
  end

  // sample strobe and bit start pulses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sampledBit    <= 1'b1;
      samplePulse   <= 1'b0;
      bitStartPulse <= 1'b0;
    end else begin
      samplePulse   <= preDone;
      bitStartPulse <= bitEnd;
      if (preDone) begin
        sampledBit <= rxInt;
      end
    end
  end

endmodule

// *** testbench/can_bus_node.sv ***
`timescale 1ns/10ps
module can_bus_node (
  // transceiver pins
  input  wire logic canTx,
  output logic      canRx,
  // other nodes on the bus
  input  wire logic otherDom
);
  // wired-and bus: any dominant node pulls the line low
  assign canRx = canTx & ~otherDom;
endmodule

// *** testbench/can_timing_irq_test_props.sv ***
`timescale 1ns/10ps
module can_timing_irq_test_props (
  // clock and reset
  input wire logic                           clk,
  input wire logic                           arst_n,
  // register port
  input wire logic [can_tim_pkg::ADDR_W-1:0] regAddr,
  input wire logic                           regRead,
  input wire logic [can_tim_pkg::DATA_W-1:0] regRdata,
  // status event
  input wire logic                           statusIrqSet,
  // timing, modes and pin
  input wire logic                           samplePulse,
  input wire logic                           bitStartPulse,
  input wire logic                           quantumTick,
  input wire logic                           basicMode,
  input wire logic                           silentMode,
  input wire logic                           loopbackMode,
  input wire logic                           canTx
);
  logic rdInt;
  logic rdTest;
  logic rdBt;
  assign rdInt  = regRead && regAddr == can_tim_pkg::IDENT_OFS;
  assign rdTest = regRead && regAddr == can_tim_pkg::TEST_OFS;
  assign rdBt   = regRead && regAddr == can_tim_pkg::BT_OFS;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_rdata_idle: assert property (!regRead |=> regRdata == '0)
    else $error("read data not zero outside a read");
  a_ident_code: assert property (rdInt |=> regRdata[31:16] == '0 &&
    (regRdata[15:0] <= 16'h0020 || regRdata[15:0] == 16'h8000))
    else $error("identifier outside legal codes");
  a_status_first: assert property (statusIrqSet ##1 rdInt |=> regRdata[15:0] == 16'h8000)
    else $error("status interrupt not reported first");
  a_tx_override: assert property (rdTest |=> !regRdata[6] || canTx == regRdata[5])
    else $error("transmit pin ignores forced level");
  a_mode_copies: assert property (rdTest |=> {basicMode, silentMode, loopbackMode} ==
    {regRdata[2], regRdata[3], regRdata[4]})
    else $error("mode outputs differ from test bits");
  a_timing_reserved: assert property (rdBt |=> regRdata[31:15] == '0)
    else $error("timing reserved bits not zero");
  a_sample_tick: assert property (samplePulse |-> $past(quantumTick))
    else $error("sample point off a quantum boundary");
  a_bitstart_tick: assert property (bitStartPulse |-> $past(quantumTick))
    else $error("bit end off a quantum boundary");
  a_sample_single: assert property (samplePulse |=> !samplePulse ##1 !samplePulse)
    else $error("sample points too close");
endmodule

bind can_timing_irq_test can_timing_irq_test_props i_props (
  .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regRead(regRead), .regRdata(regRdata),
  .statusIrqSet(statusIrqSet), .samplePulse(samplePulse), .bitStartPulse(bitStartPulse),
  .quantumTick(quantumTick), .basicMode(basicMode), .silentMode(silentMode),
  .loopbackMode(loopbackMode), .canTx(canTx)
);

// *** testbench/can_timing_irq_test_tb.sv ***
`timescale 1ns/10ps
module can_timing_irq_test_tb;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [31:0] regAddr = '0;
  logic [31:0] regWdata = '0;
  logic [31:0] regRdata;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] objIrqSet = '0;
  logic        statusIrqSet = 1'b0;
  logic        ctrlTxBit = 1'b1;
  logic        otherDom = 1'b0;
  logic        irqOut, rxBit, sampledBit, samplePulse, bitStartPulse;
  logic        quantumTick, basicMode, silentMode, loopbackMode, canRx, canTx;
  integer      seed = 32'h40744004;
  int          failCount = 0;
  int          compares = 0;
  int          cycles = 0;
  // software's own copy of pending interrupts
  int          mPend = 0;
  bit          mStat = 0;

  always #2.5 clk = ~clk;

  can_timing_irq_test i_dut (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .objIrqSet(objIrqSet), .statusIrqSet(statusIrqSet),
    .irqOut(irqOut), .ctrlTxBit(ctrlTxBit), .rxBit(rxBit), .sampledBit(sampledBit),
    .samplePulse(samplePulse), .bitStartPulse(bitStartPulse), .quantumTick(quantumTick),
    .basicMode(basicMode), .silentMode(silentMode), .loopbackMode(loopbackMode),
    .canRx(canRx), .canTx(canTx)
  );

  can_bus_node i_bus (.canTx(canTx), .otherDom(otherDom), .canRx(canRx));

  task automatic tallyAndFinish();
    if (failCount == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      failCount++;
      tallyAndFinish();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // an idle edge after each write keeps a following write from driving the strobe twice in one step
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask

  task automatic rc(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask

  task automatic ev(input logic [31:0] o, input logic s);
    objIrqSet <= o;
    statusIrqSet <= s;
    @(posedge clk);
    objIrqSet <= '0;
    statusIrqSet <= 1'b0;
    mPend |= o;
    mStat |= s;
  endtask

  // counts edges until the chosen pulse is seen, bounded at 5000, above the longest bit the test programs
  task automatic gap(input bit smp, output int p);
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while ((smp ? samplePulse : bitStartPulse) !== 1'b1 && p < 5000);
  endtask

  function automatic logic [31:0] expId();
    if (mStat) return 32'h8000;
    for (int i = 0; i < 32; i++) if (mPend[i]) return i + 1;
    return 0;
  endfunction

  initial begin
    int p, w, q, n, v, e, j;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rc("timing", can_tim_pkg::BT_OFS, 32'h2301);
    rc("ident", can_tim_pkg::IDENT_OFS, 0);
    rc("test", can_tim_pkg::TEST_OFS, 32'h80);
    rc("ext", can_tim_pkg::PEXT_OFS, 0);
    rc("unmapped", 32'h4005_0030, 0);
    gap(0, p);
    gap(0, p);
    chk("bit", 16, p);
    gap(1, p);
    chk("sample", 10, p);
    wr(can_tim_pkg::BT_OFS, 32'h7fff);
    wr(can_tim_pkg::CTRL_OFS, 32'h40);
    wr(can_tim_pkg::BT_OFS, 32'h7fff);
    rc("timing", can_tim_pkg::BT_OFS, 32'h2301);
    wr(can_tim_pkg::CTRL_OFS, 32'h41);
    for (int k = 0; k < 3; k++) begin
      v = $random(seed) & 32'hffffffdf;
      if (v[11:8] == 0) v[11:8] = 1;
      e = $random(seed) & 32'hfffffff1;
      wr(can_tim_pkg::BT_OFS, v);
      wr(can_tim_pkg::PEXT_OFS, e);
      rc("timing", can_tim_pkg::BT_OFS, v & 32'h7fff);
      rc("ext", can_tim_pkg::PEXT_OFS, e & 1);
      q = (e & 1) * 64 + (v & 31) + 1;
      n = v[11:8] + v[14:12] + 3;
      j = v[7:6] + 1;
      gap(0, p);
      gap(1, p);
      chk("sample", q * (v[11:8] + 2), p);
      gap(0, p);
      chk("post", q * (v[14:12] + 1), p);
      w = 1 + ($unsigned($random(seed)) % (n * q - 1));
      repeat (w) @(posedge clk);
      otherDom <= 1'b1;
      gap(0, p);
      otherDom <= 1'b0;
      p = p + w - n * q;
      chk("resync", 1, (p < 0 ? -p : p) <= j * q);
    end
    wr(can_tim_pkg::TEST_OFS, 32'h1c);
    rc("test", can_tim_pkg::TEST_OFS, 32'h80);
    wr(can_tim_pkg::CTRL_OFS, 32'h80);
    ctrlTxBit <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      wr(can_tim_pkg::TEST_OFS, ($random(seed) & 32'hffffff83) | (m << 5));
      if (m == 1) begin
        gap(1, p);
        @(posedge clk);
        chk("tx", 1, canTx);
      end else begin
        repeat (3) @(posedge clk);
        chk("tx", m == 3, canTx);
        rc("test", can_tim_pkg::TEST_OFS, (m << 5) | (m == 3 ? 32'h80 : 0));
      end
    end
    ctrlTxBit <= 1'b1;
    otherDom <= 1'b1;
    wr(can_tim_pkg::TEST_OFS, 32'h10);
    repeat (4) @(posedge clk);
    chk("loopback rx", 1, rxBit);
    gap(1, p);
    chk("sampled", 1, sampledBit);
    wr(can_tim_pkg::TEST_OFS, 0);
    repeat (4) @(posedge clk);
    chk("normal rx", 0, rxBit);
    gap(1, p);
    chk("sampled", 0, sampledBit);
    rc("test", can_tim_pkg::TEST_OFS, 0);
    otherDom <= 1'b0;
    ctrlTxBit <= 1'b0;
    wr(can_tim_pkg::TEST_OFS, 32'h1c);
    repeat (3) @(posedge clk);
    chk("silent tx", 1, canTx);
    chk("modes", 3'b111, {basicMode, silentMode, loopbackMode});
    rc("test", can_tim_pkg::TEST_OFS, 32'h9c);
    wr(can_tim_pkg::CTRL_OFS, 1);
    wr(can_tim_pkg::TEST_OFS, 0);
    rc("test", can_tim_pkg::TEST_OFS, 32'h9c);
    wr(can_tim_pkg::CTRL_OFS, 32'h03);
    for (int k = 0; k < 6; k++) begin
      ev($random(seed) & $random(seed), k % 3 == 0);
      rc("ident", can_tim_pkg::IDENT_OFS, expId());
      chk("irq line", expId() != 0, irqOut);
      rc("pending", can_tim_pkg::PEND_OFS, mPend);
      if (k % 2) begin
        rd(can_tim_pkg::STAT_OFS, v);
        mStat = 0;
      end else begin
        v = $random(seed);
        wr(can_tim_pkg::PEND_OFS, v);
        mPend &= ~v;
      end
      rc("ident", can_tim_pkg::IDENT_OFS, expId());
    end
    wr(can_tim_pkg::PEND_OFS, 32'hffffffff);
    rd(can_tim_pkg::STAT_OFS, v);
    rc("ident", can_tim_pkg::IDENT_OFS, 0);
    chk("irq line", 0, irqOut);
    ev(32'h8000_0000, 0);
    wr(can_tim_pkg::IDENT_OFS, 32'hffff);
    rc("ident", can_tim_pkg::IDENT_OFS, 32'h20);
    wr(can_tim_pkg::CTRL_OFS, 1);
    rc("ident", can_tim_pkg::IDENT_OFS, 32'h20);
    chk("irq line", 0, irqOut);
    tallyAndFinish();
  end
endmodule
